/* pkg/sbc_reg_defines.svh */
// register map, field positions and encodings of the register bank
`ifndef SBC_REG_DEFINES_SVH
`define SBC_REG_DEFINES_SVH

// ----------------------------------------------------------------------
// address ranges
// ----------------------------------------------------------------------
`define ADDR_CTRL_LAST      7'h1e
`define ADDR_STAT_FIRST     7'h40
`define ADDR_STAT_LAST      7'h7e

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_MODE_CTRL      7'h01
`define ADDR_HW_CTRL        7'h02
`define ADDR_CAN_CTRL       7'h04
`define ADDR_HS_CTRL1       7'h14
`define ADDR_HS_CTRL2       7'h15
`define ADDR_SUPPLY_STAT    7'h41
`define ADDR_DEVICE_STAT    7'h43
`define ADDR_BUS_STAT       7'h44
`define ADDR_WAKE_LEVEL     7'h48
`define ADDR_HS_OC_STAT     7'h54
`define ADDR_HS_OL_STAT     7'h55
`define ADDR_FAMILY_ID      7'h7e

// ----------------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------------
`define MODE_FIELD_HI       7
`define MODE_FIELD_LO       6
`define SUPPLY_FIELD_HI     5
`define SUPPLY_FIELD_LO     3
`define SECOND_SUPPLY_HI    4
`define SECOND_SUPPLY_LO    3
`define THIRD_SUPPLY_BIT    5
`define FAIL_ON_BIT         5
`define MASK_ALL            8'hff
`define MASK_HW_CTRL        8'hfb
`define MASK_CAN_CTRL       8'h07
`define CTRL_RESET          8'h00

// ----------------------------------------------------------------------
// mode field and transceiver field codes
// ----------------------------------------------------------------------
`define MODE_NORMAL         2'h0
`define MODE_STOP           2'h1
`define MODE_SLEEP          2'h2
`define MODE_RESTART        2'h3
`define CAN_OFF             3'h0
`define CAN_WAKE_CAPABLE    3'h1
`define CAN_WOKEN           3'h3

`endif

/* pkg/sbc_reg_pkg.sv */
// types shared by the register bank
package sbc_reg_pkg;

    // class of an address seen in a frame
    typedef enum logic [1:0] {
        CLASS_CONTROL,
        CLASS_STATUS,
        CLASS_UNUSED
    } access_class_t;

endpackage : sbc_reg_pkg

/* rtl/status_flag_byte.sv */
// one byte of sticky status flags with read-and-clear
`timescale 1ns/10ps

module status_flag_byte #(
    parameter logic [7:0] CLEARABLE = 8'hff
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] set_in,
    input  wire logic       clear_in,
    output logic      [7:0] flags_out
);

    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // set wins over clear; only clearable bits drop
    always_comb begin
        flags_d = flags_q;
        if (clear_in) begin
            flags_d = flags_q & ~CLEARABLE;
        end
        flags_d = flags_d | set_in;
    end

    // flag storage, untouched by mode changes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_q <= 8'h00;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;

    property p_set_wins;
        @(posedge clk_in) disable iff (!rst_n_in)
        (set_in != 8'h00) |=> ((flags_out & $past(set_in)) == $past(set_in));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status set lost");

    property p_clear_drops;
        @(posedge clk_in) disable iff (!rst_n_in)
        (clear_in && set_in == 8'h00) |=> ((flags_out & CLEARABLE) == 8'h00);
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("clear left flags");

    property p_flags_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        !clear_in |=> ((flags_out & $past(flags_out)) == $past(flags_out));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag lost without clear");

endmodule : status_flag_byte

/* rtl/sbc_register_bank.sv */
// register bank of the system basis chip behind the 16-bit serial frames
`timescale 1ns/10ps
`include "sbc_reg_defines.svh"

module sbc_register_bank #(
    parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary identity value
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        frame_valid_in,
    input  wire logic [15:0] frame_word_in,
    input  wire logic        mode_change_in,
    input  wire logic [1:0]  mode_entered_in,
    input  wire logic        second_supply_standalone_in,
    input  wire logic        can_wake_in,
    input  wire logic        fail_trigger_in,
    input  wire logic [7:0]  supply_event_in,
    input  wire logic [7:0]  device_event_in,
    input  wire logic [7:0]  bus_event_in,
    input  wire logic [3:0]  hs_fault_in,
    input  wire logic [3:0]  hs_open_load_in,
    input  wire logic [2:0]  wake_pin_in,
    output logic             resp_valid_out,
    output logic      [7:0]  resp_data_out,
    output logic      [1:0]  mode_field_out,
    output logic      [2:0]  can_control_out,
    output logic      [15:0] hs_config_out,
    output logic      [1:0]  second_supply_output_out,
    output logic             third_supply_output_out,
    output logic             fail_output_out
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam int         CTRL_COUNT = 31;
    localparam logic [4:0] IDX_MODE   = 5'(`ADDR_MODE_CTRL);
    localparam logic [4:0] IDX_HW     = 5'(`ADDR_HW_CTRL);
    localparam logic [4:0] IDX_CAN    = 5'(`ADDR_CAN_CTRL);
    localparam logic [4:0] IDX_HS1    = 5'(`ADDR_HS_CTRL1);
    localparam logic [4:0] IDX_HS2    = 5'(`ADDR_HS_CTRL2);

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [2:0] wake_meta_q;
    logic [2:0] wake_sync_q;

    // two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // wake pin levels come from outside, two flops first
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wake_meta_q <= 3'h0;
            wake_sync_q <= 3'h0;
        end else begin
            wake_meta_q <= wake_pin_in;
            wake_sync_q <= wake_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    logic [7:0]                 ctrl_q [0:CTRL_COUNT-1];
    logic [7:0]                 ctrl_d [0:CTRL_COUNT-1];
    logic [6:0]                 addr;
    logic                       type_bit;
    logic [7:0]                 wdata;
    logic [4:0]                 idx;
    logic                       in_restart;
    logic                       in_normal;
    logic                       frame_ok;
    logic                       write_en;
    logic                       clear_en;
    sbc_reg_pkg::access_class_t cls;

    // address low, type bit, data byte high
    assign addr       = frame_word_in[6:0];
    assign type_bit   = frame_word_in[7];
    assign wdata      = frame_word_in[15:8];
    assign idx        = addr[4:0];
    assign in_restart = (mode_field_out == `MODE_RESTART);
    assign in_normal  = (mode_field_out == `MODE_NORMAL);
    assign frame_ok   = frame_valid_in && !in_restart;

    // address class
    always_comb begin
        if (addr <= `ADDR_CTRL_LAST) begin
            cls = sbc_reg_pkg::CLASS_CONTROL;
        end else if (addr >= `ADDR_STAT_FIRST && addr <= `ADDR_STAT_LAST) begin
            cls = sbc_reg_pkg::CLASS_STATUS;
        end else begin
            cls = sbc_reg_pkg::CLASS_UNUSED;
        end
    end

    // type bit selects write or read-clear
    assign write_en = frame_ok && cls == sbc_reg_pkg::CLASS_CONTROL && type_bit;
    assign clear_en = frame_ok && cls == sbc_reg_pkg::CLASS_STATUS && type_bit;

    // writable bits per configuration register
    function automatic logic [7:0] ctrl_mask(input logic [4:0] a);
        case (a)
            IDX_HW:  ctrl_mask = `MASK_HW_CTRL;
            IDX_CAN: ctrl_mask = `MASK_CAN_CTRL;
            default: ctrl_mask = `MASK_ALL;
        endcase
    endfunction : ctrl_mask

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] mode_wr;
    logic [2:0] can_old;

    // next values: write, then fault switch-off, then mode entry
    always_comb begin
        for (int i = 0; i < CTRL_COUNT; i++) begin
            ctrl_d[i] = ctrl_q[i];
        end
        can_old = ctrl_q[IDX_CAN][2:0];
        mode_wr = wdata;
        if (!in_normal) begin
            mode_wr[`SUPPLY_FIELD_HI:`SUPPLY_FIELD_LO] =
                ctrl_q[IDX_MODE][`SUPPLY_FIELD_HI:`SUPPLY_FIELD_LO];
        end
        if (write_en) begin
            case (idx)
                IDX_MODE: ctrl_d[IDX_MODE] = mode_wr;
                IDX_HS1: begin
                    if (in_normal) begin
                        ctrl_d[IDX_HS1] = wdata;
                    end
                end
                IDX_HS2: begin
                    if (in_normal) begin
                        ctrl_d[IDX_HS2] = wdata;
                    end
                end
                default: ctrl_d[idx] = wdata & ctrl_mask(idx);
            endcase
        end
        // overcurrent/overtemperature turns the switch off, no wake issued
        for (int s = 0; s < 2; s++) begin
            if (hs_fault_in[s]) begin
                ctrl_d[IDX_HS1][s*4 +: 4] = 4'h0;
            end
            if (hs_fault_in[s+2]) begin
                ctrl_d[IDX_HS2][s*4 +: 4] = 4'h0;
            end
        end
        if (mode_change_in) begin
            ctrl_d[IDX_MODE][`MODE_FIELD_HI:`MODE_FIELD_LO] = mode_entered_in;
            case (mode_entered_in)
                `MODE_SLEEP: begin
                    if (can_old != `CAN_OFF && can_old != `CAN_WAKE_CAPABLE) begin
                        ctrl_d[IDX_CAN] = {5'h00, `CAN_WAKE_CAPABLE};
                    end
                end
                `MODE_RESTART: begin
                    ctrl_d[IDX_HS1] = 8'h00;
                    ctrl_d[IDX_HS2] = 8'h00;
                    if (second_supply_standalone_in) begin
                        ctrl_d[IDX_MODE][`SECOND_SUPPLY_HI:`SECOND_SUPPLY_LO] = 2'h0;
                    end
                    if (can_old == `CAN_OFF) begin
                        ctrl_d[IDX_CAN] = {5'h00, `CAN_OFF};
                    end else if (can_old == `CAN_WAKE_CAPABLE && !can_wake_in) begin
                        ctrl_d[IDX_CAN] = {5'h00, `CAN_WAKE_CAPABLE};
                    end else begin
                        ctrl_d[IDX_CAN] = {5'h00, `CAN_WOKEN};
                    end
                end
                // stop and normal leave transceiver and switches as they are
                default: ctrl_d[IDX_CAN] = ctrl_d[IDX_CAN];
            endcase
        end
    end

    // configuration storage
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < CTRL_COUNT; i++) begin
                ctrl_q[i] <= `CTRL_RESET;
            end
        end else begin
            for (int i = 0; i < CTRL_COUNT; i++) begin
                ctrl_q[i] <= ctrl_d[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------------
    logic [7:0] supply_flags;
    logic [7:0] device_flags;
    logic [7:0] bus_flags;
    logic [7:0] hs_oc_flags;
    logic [7:0] hs_ol_flags;

    status_flag_byte #(.CLEARABLE(8'hff)) u_supply_stat (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n_q),
        .set_in    (supply_event_in),
        .clear_in  (clear_en && addr == `ADDR_SUPPLY_STAT),
        .flags_out (supply_flags)
    );

    status_flag_byte #(.CLEARABLE(8'hff)) u_device_stat (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n_q),
        .set_in    (device_event_in),
        .clear_in  (clear_en && addr == `ADDR_DEVICE_STAT),
        .flags_out (device_flags)
    );

    status_flag_byte #(.CLEARABLE(8'hff)) u_bus_stat (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n_q),
        .set_in    (bus_event_in),
        .clear_in  (clear_en && addr == `ADDR_BUS_STAT),
        .flags_out (bus_flags)
    );

    status_flag_byte #(.CLEARABLE(8'h0f)) u_hs_oc_stat (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n_q),
        .set_in    ({4'h0, hs_fault_in}),
        .clear_in  (clear_en && addr == `ADDR_HS_OC_STAT),
        .flags_out (hs_oc_flags)
    );

    status_flag_byte #(.CLEARABLE(8'h0f)) u_hs_ol_stat (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n_q),
        .set_in    ({4'h0, hs_open_load_in}),
        .clear_in  (clear_en && addr == `ADDR_HS_OL_STAT),
        .flags_out (hs_ol_flags)
    );

    // ------------------------------------------------------------------
    // read-back and response
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       resp_valid_q;
    logic [7:0] resp_data_q;

    // contents before this frame's write or clear
    always_comb begin
        rd_byte = 8'h00;
        if (cls == sbc_reg_pkg::CLASS_CONTROL) begin
            rd_byte = ctrl_q[idx];
        end else if (cls == sbc_reg_pkg::CLASS_STATUS) begin
            case (addr)
                `ADDR_SUPPLY_STAT: rd_byte = supply_flags;
                `ADDR_DEVICE_STAT: rd_byte = device_flags;
                `ADDR_BUS_STAT:    rd_byte = bus_flags;
                `ADDR_HS_OC_STAT:  rd_byte = hs_oc_flags;
                `ADDR_HS_OL_STAT:  rd_byte = hs_ol_flags;
                `ADDR_WAKE_LEVEL:  rd_byte = {5'h00, wake_sync_q};
                `ADDR_FAMILY_ID:   rd_byte = FAMILY_ID;
                default:           rd_byte = 8'h00;
            endcase
        end
    end

    // one response per interpreted frame
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            resp_valid_q <= 1'b0;
            resp_data_q  <= 8'h00;
        end else begin
            resp_valid_q <= frame_ok;
            if (frame_ok) begin
                resp_data_q <= rd_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // fail output
    // ------------------------------------------------------------------
    logic fail_latched_q;
    logic fail_out_q;

    // once triggered it stays on through every mode until reset
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fail_latched_q <= 1'b0;
            fail_out_q     <= 1'b0;
        end else begin
            fail_latched_q <= fail_latched_q | fail_trigger_in;
            fail_out_q     <= fail_latched_q | fail_trigger_in | ctrl_d[IDX_HW][`FAIL_ON_BIT];
        end
    end

    // drivers follow configuration only, failure flags do not gate them
    assign hs_config_out            = {ctrl_q[IDX_HS2], ctrl_q[IDX_HS1]};
    assign mode_field_out           = ctrl_q[IDX_MODE][`MODE_FIELD_HI:`MODE_FIELD_LO];
    assign second_supply_output_out = ctrl_q[IDX_MODE][`SECOND_SUPPLY_HI:`SECOND_SUPPLY_LO];
    assign third_supply_output_out  = ctrl_q[IDX_MODE][`THIRD_SUPPLY_BIT];
    assign can_control_out          = ctrl_q[IDX_CAN][2:0];
    assign resp_valid_out           = resp_valid_q;
    assign resp_data_out            = resp_data_q;
    assign fail_output_out          = fail_out_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_can_write;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (write_en && addr == `ADDR_CAN_CTRL && !mode_change_in)
            |=> (can_control_out == $past(wdata[2:0]));
    endproperty
    a_can_write: assert property (p_can_write) else $error("write not stored");

    property p_old_in_resp;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (frame_ok && addr == `ADDR_CAN_CTRL)
            |=> (resp_data_out == {5'h00, $past(can_control_out)});
    endproperty
    a_old_in_resp: assert property (p_old_in_resp) else $error("response not old value");

    property p_family_fixed;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (frame_ok && addr == `ADDR_FAMILY_ID) |=> (resp_data_out == FAMILY_ID);
    endproperty
    a_family_fixed: assert property (p_family_fixed) else $error("identity changed");

    property p_mode_follows;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        mode_change_in |=> (mode_field_out == $past(mode_entered_in));
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode field stale");

    property p_fail_stays;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        fail_trigger_in |=> fail_output_out [*4];
    endproperty
    a_fail_stays: assert property (p_fail_stays) else $error("fail output dropped");

    property p_stop_can;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (mode_change_in && mode_entered_in == `MODE_STOP && !write_en) |=> $stable(can_control_out);
    endproperty
    a_stop_can: assert property (p_stop_can) else $error("stop changed transceiver");

    property p_sleep_can;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (mode_change_in && mode_entered_in == `MODE_SLEEP)
            |=> (can_control_out == `CAN_OFF || can_control_out == `CAN_WAKE_CAPABLE);
    endproperty
    a_sleep_can: assert property (p_sleep_can) else $error("sleep transceiver not safe");

    property p_hs_locked;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (!in_normal && hs_fault_in == 4'h0 && !mode_change_in) |=> $stable(hs_config_out);
    endproperty
    a_hs_locked: assert property (p_hs_locked) else $error("switch config changed");

    property p_fault_off;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        hs_fault_in[0] |=> (hs_config_out[3:0] == 4'h0);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("faulty switch still on");

    property p_restart_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (mode_change_in && mode_entered_in == `MODE_RESTART) |=> (hs_config_out == 16'h0000);
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart kept switches");

    property p_restart_off;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (mode_change_in && mode_entered_in == `MODE_RESTART && can_control_out == `CAN_OFF)
            |=> (can_control_out == `CAN_OFF);
    endproperty
    a_restart_off: assert property (p_restart_off) else $error("restart woke off transceiver");

    property p_restart_mute;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (frame_valid_in && in_restart) |=> !resp_valid_out;
    endproperty
    a_restart_mute: assert property (p_restart_mute) else $error("frame taken in restart");

    property p_reserved_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (frame_ok && addr == `ADDR_CAN_CTRL) |=> (resp_data_out[7:3] == 5'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

endmodule : sbc_register_bank

/* dv/uc_model.sv */
// microcontroller side: sends whole 16-bit frames
`timescale 1ns/10ps
module uc_model (
    input  wire logic        clk_in,
    output logic             frame_valid_out,
    output logic      [15:0] frame_word_out
);
    // idle bus at time zero
    initial begin
        frame_valid_out = 1'b0;
        frame_word_out  = 16'h0000;
    end
    // one frame: data high, type bit, address low
    task automatic xfer(input logic [7:0] d, input logic t, input logic [6:0] a);
        @(posedge clk_in);
        frame_valid_out <= 1'b1;
        frame_word_out  <= {d, t, a};
        @(posedge clk_in);
        frame_valid_out <= 1'b0;
        frame_word_out  <= ~{d, t, a}; // no stale word
    endtask : xfer
endmodule : uc_model

/* dv/tb_sbc_register_bank.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
module tb_sbc_register_bank;
    logic        ref_clk_in, reset_n_in, fv, mchg, alone, rv, s3, fo, fl, cw;
    logic [15:0] fw, hs;
    logic [1:0]  ment, mf, s2;
    logic [2:0]  wk, can;
    logic [7:0]  sup, rd, d;
    logic [3:0]  hf;
    logic [6:0]  ad[3] = '{7'h04, 7'h10, 7'h1e};
    logic [6:0]  sa[5] = '{7'h41, 7'h43, 7'h44, 7'h48, 7'h7e};
    int          m[128], n_mismatch, n_checks, seed;

    sbc_register_bank sbc_register_bank_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .frame_valid_in(fv), .frame_word_in(fw), .mode_change_in(mchg), .mode_entered_in(ment),
        .second_supply_standalone_in(alone), .can_wake_in(cw), .fail_trigger_in(fl),
        .supply_event_in(sup), .device_event_in(sup), .bus_event_in(sup), .hs_fault_in(hf),
        .hs_open_load_in(hf), .wake_pin_in(wk), .resp_valid_out(rv), .resp_data_out(rd),
        .mode_field_out(mf), .can_control_out(can), .hs_config_out(hs),
        .second_supply_output_out(s2), .third_supply_output_out(s3), .fail_output_out(fo));
    uc_model uc_model_i (.clk_in(ref_clk_in), .frame_valid_out(fv), .frame_word_out(fw));

    // compare one value
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one frame; model answers old byte, then stores or clears
    task automatic acc(input logic [7:0] dd, input logic t, input logic [6:0] a, input logic ok);
        uc_model_i.xfer(dd, t, a);
        #1;
        chk({7'h0, rv}, {7'h0, ok});
        if (ok) chk(rd, m[a][7:0]);
        if (ok && t && a <= 7'h1e && !(a[6:1] == 6'h0a && mf !== 2'h0))
            m[a] = dd & (a == 7'h04 ? 8'h07 : 8'hff);
        if (ok && t && (a == 7'h41 || a == 7'h43 || a == 7'h44))
            m[a] = 0;
    endtask : acc
    // announce a mode change
    task automatic mode(input logic [1:0] md);
        @(posedge ref_clk_in);
        mchg <= 1'b1;
        ment <= md;
        @(posedge ref_clk_in);
        mchg <= 1'b0;
        #1;
        m[1] = {md, m[1][5:0]};
        chk({6'h0, mf}, {6'h0, md});
    endtask : mode
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    // main sequence
    initial begin
        seed = 32'hb2148e65;
        {reset_n_in, mchg, alone, ment, sup, hf, wk, fl, cw} = '0;
        m[7'h7e] = 8'h5a; // arbitrary identity value
        repeat (3) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        foreach (ad[i]) begin
            d = 8'($random(seed));
            acc(d, 1'b0, ad[i], 1'b1);
            acc(d, 1'b1, ad[i], 1'b1);
            acc(~d, 1'b0, ad[i], 1'b1);
        end
        acc(8'hff, 1'b1, 7'h20, 1'b1);
        $display("test control done");
        @(posedge ref_clk_in);
        sup <= 8'h81;
        wk <= 3'h5;
        @(posedge ref_clk_in);
        sup <= 8'h00;
        m[7'h41] = 8'h81;
        m[7'h43] = 8'h81;
        m[7'h44] = 8'h81;
        m[7'h48] = 5;
        repeat (3) @(posedge ref_clk_in);
        foreach (sa[i]) begin
            acc(8'h00, 1'b0, sa[i], 1'b1);
            acc(8'h00, 1'b1, sa[i], 1'b1);
            acc(8'h00, 1'b0, sa[i], 1'b1);
        end
        acc(8'hff, 1'b1, 7'h14, 1'b1);
        @(posedge ref_clk_in);
        hf <= 4'h1;
        @(posedge ref_clk_in);
        hf <= 4'h0;
        #1;
        chk(hs[7:0], 8'hf0);
        m[7'h14] = 8'hf0;
        m[7'h54] = 1;
        m[7'h55] = 1;
        acc(8'hff, 1'b1, 7'h14, 1'b1);
        chk(hs[7:0], 8'hff);
        acc(8'h00, 1'b0, 7'h54, 1'b1);
        acc(8'h00, 1'b0, 7'h55, 1'b1);
        $display("test status done");
        acc(8'h38, 1'b1, 7'h01, 1'b1);
        acc(8'h02, 1'b1, 7'h04, 1'b1);
        mode(2'h1);
        chk({5'h0, can}, 8'h02);
        mode(2'h2);
        chk({5'h0, can}, 8'h01);
        chk({5'h0, s3, s2}, 8'h07);
        m[4] = 1;
        @(posedge ref_clk_in);
        fl <= 1'b1;
        @(posedge ref_clk_in);
        fl <= 1'b0;
        #1;
        chk({7'h0, fo}, 8'h01);
        acc(8'hff, 1'b1, 7'h15, 1'b1);
        chk(hs[11:4], 8'h0f);
        alone <= 1'b1;
        mode(2'h3);
        m[7'h14] = 0;
        m[1][4:3] = 2'h0;
        chk(hs[7:0], 8'h00);
        chk({5'h0, s3, s2}, 8'h04);
        chk({7'h0, fo}, 8'h01);
        chk({5'h0, can}, 8'h01);
        acc(8'hff, 1'b1, 7'h04, 1'b0);
        chk({5'h0, can}, 8'h01);
        cw <= 1'b1;
        mode(2'h3);
        chk({5'h0, can}, 8'h03);
        m[4] = 3;
        mode(2'h0);
        acc(8'h00, 1'b1, 7'h04, 1'b1);
        acc(8'h00, 1'b0, 7'h01, 1'b1);
        mode(2'h3);
        chk({5'h0, can}, 8'h00);
        mode(2'h0);
        $display("test modes done");
        @(posedge ref_clk_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({7'h0, fo}, 8'h00);
        acc(8'h00, 1'b0, 7'h04, 1'b1);
        $display("test reset done");
        report_and_stop();
    end
endmodule : tb_sbc_register_bank
